// >>> hw/mct_motor_capture_timer.sv
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module mct_motor_capture_timer
    import mct_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic aclk, // System clock, used as high-speed clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [5:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [5:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic pwm_periodic_signal, // Alternative count clock
    input wire logic hall_input_a, // Hall sensor a
    input wire logic hall_input_b, // Hall sensor b
    input wire logic hall_input_c, // Hall sensor c
    input wire logic general_capture_pin, // General capture input
    output logic irq // Level interrupt
);
    mct_ctrl_a_s ctrl_a_q;
    mct_ctrl_b_s ctrl_b_q;
    logic [CNT_W-1:0] cnt_q, cmp_q, cap_q;
    logic [1:0] sts_q, msk_q;
    logic on_q, pwm_q, raw_q, filt_q, sel_q, ck_q;
    logic [6:0] pre_q;
    logic [1:0] slow_q;
    logic [2:0] run_q;
    logic irq_q;

    // Write channel: address and data taken in any order, then response
    logic aw_hold_q, w_hold_q;
    logic [5:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    mct_bus_e wr_st_q, rd_st_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q, bresp_q;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_hold_q || aw_take;
    wire w_have = w_hold_q || w_take;
    wire wr_fire = aw_have && w_have && wr_st_q == MCT_IDLE;
    wire [5:0] wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wd = w_hold_q ? wdata_q : s_axi_wdata;
    wire [3:0] ws = w_hold_q ? wstrb_q : s_axi_wstrb;
    wire wr_lane = wr_fire && ws[0];
    wire wr_ok = wa == MCT_OFF_CTRL_A || wa == MCT_OFF_CTRL_B || wa == MCT_OFF_CNT_LO
        || wa == MCT_OFF_CNT_HI || wa == MCT_OFF_CMP_LO || wa == MCT_OFF_CMP_HI
        || wa == MCT_OFF_CAP_LO || wa == MCT_OFF_CAP_HI || wa == MCT_OFF_IRQ_STATUS
        || wa == MCT_OFF_IRQ_MASK;

    // Capture input path
    wire sel_in = ctrl_a_q.src_sel == 2'b00 ? hall_input_a :
        ctrl_a_q.src_sel == 2'b01 ? hall_input_b :
        ctrl_a_q.src_sel == 2'b10 ? hall_input_c : general_capture_pin;
    wire samp_tick = !ctrl_b_q.samp_clk || slow_q == MCT_SLOW_TICK;
    wire [2:0] need = ctrl_b_q.samp_cnt ? MCT_FILT_LONG : MCT_FILT_SHORT;
    wire path_lvl = ctrl_b_q.filt_en ? filt_q : raw_q;
    wire rise = path_lvl && !sel_q;
    wire fall = !path_lvl && sel_q;
    wire edge_hit = (ctrl_b_q.edge_sel == MCT_EDGE_RISE && rise)
        || (ctrl_b_q.edge_sel == MCT_EDGE_FALL && fall)
        || (ctrl_b_q.edge_sel == MCT_EDGE_BOTH && (rise || fall));
    wire cap_ev = edge_hit && ctrl_b_q.cap_en && ctrl_a_q.timer_on;

    // Counter clock: PWM edge or prescaler carry
    wire [2:0] ck = ctrl_a_q.clk_sel;
    wire div_tick = ck != MCT_CK_PWM && pre_q[ck - 3'd1] && !ck_q;
    wire pwm_tick = ck == MCT_CK_PWM && pwm_periodic_signal && !pwm_q;
    wire cnt_tick = (div_tick || pwm_tick) && ctrl_a_q.timer_on && !ctrl_a_q.pause;
    wire cmp_hit = ctrl_a_q.timer_on && cnt_q == cmp_q;
    wire cmp_ev = cmp_hit && cnt_tick;
    wire on_rise = ctrl_a_q.timer_on && !on_q;

    logic [CNT_W-1:0] cnt_d;
    always_comb begin
        cnt_d = cnt_q;
        if (on_rise) begin
            cnt_d = '0;
        end else if (cap_ev && ctrl_b_q.cap_clr) begin
            cnt_d = '0;
        end else if (cmp_ev && ctrl_b_q.cmp_clr) begin
            cnt_d = '0;
        end else if (cnt_tick) begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    wire [1:0] sts_set = {cmp_ev, cap_ev};
    wire [1:0] sts_clr = (wr_lane && wa == MCT_OFF_IRQ_STATUS) ? wd[1:0] : 2'b00;
    wire [1:0] sts_d = (sts_q & ~sts_clr) | sts_set;
    wire [1:0] msk_d = (wr_lane && wa == MCT_OFF_IRQ_MASK) ? wd[1:0] : msk_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
            cap_q <= '0;
            on_q <= 1'b0;
            pwm_q <= 1'b0;
            ck_q <= 1'b0;
            pre_q <= MCT_PRE_RST;
        end else begin
            on_q <= ctrl_a_q.timer_on;
            pwm_q <= pwm_periodic_signal;
            pre_q <= pre_q + 7'd1;
            ck_q <= ck == MCT_CK_PWM ? 1'b0 : pre_q[ck - 3'd1];
            cnt_q <= cnt_d;
            if (cap_ev) begin
                cap_q <= cnt_q;
            end
        end
    end

    // Filter: level accepted after identical run of samples
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raw_q <= 1'b0;
            filt_q <= 1'b0;
            sel_q <= 1'b0;
            run_q <= 3'd0;
            slow_q <= 2'd0;
        end else begin
            raw_q <= sel_in;
            sel_q <= path_lvl;
            slow_q <= slow_q + 2'd1;
            if (samp_tick) begin
                if (raw_q == filt_q) begin
                    run_q <= 3'd0;
                end else if (run_q >= need) begin
                    filt_q <= raw_q;
                    run_q <= 3'd0;
                end else begin
                    run_q <= run_q + 3'd1;
                end
            end
        end
    end

    // Registers and interrupt; hardware set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_a_q <= MCT_RST_CTRL;
            ctrl_b_q <= MCT_RST_CTRL;
            cmp_q <= MCT_RST_CMP;
            sts_q <= 2'b00;
            msk_q <= 2'b00;
            irq_q <= 1'b0;
        end else begin
            if (wr_lane && wa == MCT_OFF_CTRL_A) ctrl_a_q <= wd[7:0] & MCT_A_WMASK;
            if (wr_lane && wa == MCT_OFF_CTRL_B) ctrl_b_q <= wd[7:0];
            if (wr_lane && wa == MCT_OFF_CMP_LO) cmp_q[7:0] <= wd[7:0];
            if (wr_lane && wa == MCT_OFF_CMP_HI) cmp_q[15:8] <= wd[7:0];
            msk_q <= msk_d;
            sts_q <= sts_d;
            // Next values, so irq never lags a mask write
            irq_q <= |(sts_d & msk_d);
        end
    end

    // Bus channel state
    wire rd_take = s_axi_arvalid && s_axi_arready;
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b1;
        case (s_axi_araddr)
            MCT_OFF_CTRL_A: rd_mux[7:0] = ctrl_a_q;
            MCT_OFF_CTRL_B: rd_mux[7:0] = ctrl_b_q;
            MCT_OFF_CNT_LO: rd_mux[7:0] = cnt_q[7:0];
            MCT_OFF_CNT_HI: rd_mux[7:0] = cnt_q[15:8];
            MCT_OFF_CMP_LO: rd_mux[7:0] = cmp_q[7:0];
            MCT_OFF_CMP_HI: rd_mux[7:0] = cmp_q[15:8];
            MCT_OFF_CAP_LO: rd_mux[7:0] = cap_q[7:0];
            MCT_OFF_CAP_HI: rd_mux[7:0] = cap_q[15:8];
            MCT_OFF_IRQ_STATUS: rd_mux[1:0] = sts_q;
            MCT_OFF_IRQ_MASK: rd_mux[1:0] = msk_q;
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 6'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            wr_st_q <= MCT_IDLE;
            bresp_q <= MCT_RESP_OKAY;
            rd_st_q <= MCT_IDLE;
            rdata_q <= 32'h0000_0000;
            rresp_q <= MCT_RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                wr_st_q <= MCT_RESP;
                bresp_q <= wr_ok ? MCT_RESP_OKAY : MCT_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_hold_q <= 1'b1;
                    awaddr_q <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_hold_q <= 1'b1;
                    wdata_q <= s_axi_wdata;
                    wstrb_q <= s_axi_wstrb;
                end
                if (wr_st_q == MCT_RESP && s_axi_bready) wr_st_q <= MCT_IDLE;
            end
            if (rd_take) begin
                rd_st_q <= MCT_RESP;
                rdata_q <= rd_mux;
                rresp_q <= rd_ok ? MCT_RESP_OKAY : MCT_RESP_SLVERR;
            end else if (rd_st_q == MCT_RESP && s_axi_rready) begin
                rd_st_q <= MCT_IDLE;
            end
        end
    end

    // Readies registered from the next channel state, so each is a flop
    logic awr_q, wr_q, arr_q;
    wire aw_hold_d = !wr_fire && aw_have;
    wire w_hold_d = !wr_fire && w_have;
    wire wr_resp_d = wr_fire || (wr_st_q == MCT_RESP && !s_axi_bready);
    wire rd_resp_d = rd_take || (rd_st_q == MCT_RESP && !s_axi_rready);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awr_q <= 1'b0;
            wr_q <= 1'b0;
            arr_q <= 1'b0;
        end else begin
            awr_q <= !aw_hold_d && !wr_resp_d;
            wr_q <= !w_hold_d && !wr_resp_d;
            arr_q <= !rd_resp_d;
        end
    end

    assign s_axi_awready = awr_q;
    assign s_axi_wready = wr_q;
    assign s_axi_arready = arr_q;
    assign s_axi_bvalid = wr_st_q == MCT_RESP;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rd_st_q == MCT_RESP;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign irq = irq_q;

    property p_cnt_zero_on_start;
        @(posedge aclk) disable iff (!aresetn) on_rise |=> cnt_q == '0;
    endproperty
    a_cnt_zero_on_start: assert property (p_cnt_zero_on_start)
        else $error("no clear on start");

    property p_pause_hold;
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_a_q.pause && !on_rise && !cap_ev) |=> cnt_q == $past(cnt_q);
    endproperty
    a_pause_hold: assert property (p_pause_hold)
        else $error("count moved in pause");

    property p_off_hold;
        @(posedge aclk) disable iff (!aresetn)
        (!ctrl_a_q.timer_on && !$past(ctrl_a_q.timer_on)) |-> cnt_q == $past(cnt_q);
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("count moved while off");

    property p_cap_load;
        @(posedge aclk) disable iff (!aresetn)
        cap_ev |=> cap_q == $past(cnt_q) && sts_q[MCT_IRQ_CAP];
    endproperty
    a_cap_load: assert property (p_cap_load)
        else $error("capture not taken");

    property p_cap_clear;
        @(posedge aclk) disable iff (!aresetn)
        (cap_ev && ctrl_b_q.cap_clr) |=> cnt_q == '0;
    endproperty
    a_cap_clear: assert property (p_cap_clear)
        else $error("no clear on capture");

    property p_cmp_clear;
        @(posedge aclk) disable iff (!aresetn)
        (cmp_ev && ctrl_b_q.cmp_clr && !on_rise) |=> cnt_q == '0;
    endproperty
    a_cmp_clear: assert property (p_cmp_clear)
        else $error("no clear on match");

    property p_cmp_flag;
        @(posedge aclk) disable iff (!aresetn) cmp_ev |=> sts_q[MCT_IRQ_CMP];
    endproperty
    a_cmp_flag: assert property (p_cmp_flag)
        else $error("match flag missing");

    property p_cap_gate;
        @(posedge aclk) disable iff (!aresetn)
        (!ctrl_a_q.timer_on || !ctrl_b_q.cap_en || ctrl_b_q.edge_sel == MCT_EDGE_OFF)
        |=> cap_q == $past(cap_q);
    endproperty
    a_cap_gate: assert property (p_cap_gate)
        else $error("capture while gated");

    property p_irq_level;
        @(posedge aclk) disable iff (!aresetn) ##1 irq == |(sts_q & msk_q);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("irq mismatch");

    // Counter steps by one on a plain tick; every clear takes priority
    sequence s_plain_tick;
        cnt_tick && !on_rise && !(cap_ev && ctrl_b_q.cap_clr) && !(cmp_ev && ctrl_b_q.cmp_clr);
    endsequence

    property p_cnt_step;
        @(posedge aclk) disable iff (!aresetn)
        s_plain_tick |=> cnt_q == $past(cnt_q) + 1'b1;
    endproperty
    a_cnt_step: assert property (p_cnt_step)
        else $error("count did not step");

    // Slow filter clock: filtered level and run count hold between sample ticks
    property p_slow_samp;
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_b_q.filt_en && ctrl_b_q.samp_clk && !samp_tick)
        |=> filt_q == $past(filt_q) && run_q == $past(run_q);
    endproperty
    a_slow_samp: assert property (p_slow_samp)
        else $error("filter moved between samples");

    // One write and one read at a time; answers drop once taken
    property p_one_wr;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_one_wr: assert property (p_one_wr)
        else $error("write taken while answering");

    property p_one_rd;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_one_rd: assert property (p_one_rd)
        else $error("read taken while answering");

    property p_b_drop;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_drop: assert property (p_b_drop)
        else $error("write answer repeated");

    property p_r_drop;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_drop: assert property (p_r_drop)
        else $error("read answer repeated");
endmodule

// >>> hw/mct_pkg.sv
package mct_pkg;
    localparam logic [5:0] MCT_OFF_CTRL_A = 6'h00;
    localparam logic [5:0] MCT_OFF_CTRL_B = 6'h04;
    localparam logic [5:0] MCT_OFF_CNT_LO = 6'h08;
    localparam logic [5:0] MCT_OFF_CNT_HI = 6'h0c;
    localparam logic [5:0] MCT_OFF_CMP_LO = 6'h10;
    localparam logic [5:0] MCT_OFF_CMP_HI = 6'h14;
    localparam logic [5:0] MCT_OFF_CAP_LO = 6'h18;
    localparam logic [5:0] MCT_OFF_CAP_HI = 6'h1c;
    localparam logic [5:0] MCT_OFF_IRQ_STATUS = 6'h20;
    localparam logic [5:0] MCT_OFF_IRQ_MASK = 6'h24;
    localparam logic [7:0] MCT_RST_CTRL = 8'h00;
    localparam logic [15:0] MCT_RST_CMP = 16'h0000;
    localparam logic [1:0] MCT_RESP_OKAY = 2'b00;
    localparam logic [1:0] MCT_RESP_SLVERR = 2'b10;
    // Control A fields
    localparam int MCT_A_PAUSE = 7;
    localparam int MCT_A_CKSEL = 4;
    localparam int MCT_A_ON = 3;
    localparam int MCT_A_SRC = 0;
    // Control B fields
    localparam int MCT_B_EDGE = 6;
    localparam int MCT_B_CAPTURE_INPUT_ENABLE = 5;
    localparam int MCT_B_NCNT = 4;
    localparam int MCT_B_NCLK = 3;
    localparam int MCT_B_FILT = 2;
    localparam int MCT_B_CAPTURE_AUTO_CLEAR = 1;
    localparam int MCT_B_CMPCLR = 0;
    localparam logic [7:0] MCT_A_WMASK = 8'hfb;
    // Status bits
    localparam int MCT_IRQ_CAP = 0;
    localparam int MCT_IRQ_CMP = 1;
    localparam logic [2:0] MCT_CK_PWM = 3'b000;
    localparam logic [1:0] MCT_EDGE_OFF = 2'b00;
    localparam logic [1:0] MCT_EDGE_RISE = 2'b01;
    localparam logic [1:0] MCT_EDGE_FALL = 2'b10;
    localparam logic [1:0] MCT_EDGE_BOTH = 2'b11;
    localparam logic [2:0] MCT_FILT_SHORT = 3'd1;
    localparam logic [2:0] MCT_FILT_LONG = 3'd3;
    localparam logic [1:0] MCT_SLOW_TICK = 2'd3;
    localparam logic [6:0] MCT_PRE_RST = 7'h00;

    typedef struct packed {
        logic pause;
        logic [2:0] clk_sel;
        logic timer_on;
        logic spare;
        logic [1:0] src_sel;
    } mct_ctrl_a_s;

    typedef struct packed {
        logic [1:0] edge_sel;
        logic cap_en;
        logic samp_cnt;
        logic samp_clk;
        logic filt_en;
        logic cap_clr;
        logic cmp_clr;
    } mct_ctrl_b_s;

    typedef enum logic [0:0] {MCT_IDLE, MCT_RESP} mct_bus_e;
endpackage

// >>> tb/mct_pin_model.sv
`timescale 1ns/1ps
module mct_pin_model (
    input wire logic aclk, // Bench clock
    input wire logic go, // Start a level change
    input wire logic [1:0] sel, // Pin to move
    input wire logic lvl, // New level
    input wire logic [7:0] width, // Pulse length, 0 keeps the level
    output logic [3:0] pins // Hall a, b, c, general pin
);
    int left = 0;
    logic [1:0] cur = 2'd0;
    logic [3:0] lvl_q = 4'h0;
    assign pins = lvl_q;
    // Sensors are always driven, so no released state to model
    always @(posedge aclk) begin
        if (go) begin
            lvl_q[sel] <= lvl;
            cur <= sel;
            left <= width;
        end else if (left != 0) begin
            left <= left - 1;
            if (left == 1) begin
                lvl_q[cur] <= ~lvl_q[cur];
            end
        end
    end
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %0t mismatch got %0h exp %0h", $time, (g), (e)); end end
module tb;
    import mct_pkg::*;
    logic aclk = 0;
    logic aresetn = 0;
    logic [5:0] awaddr = 0;
    logic [5:0] araddr = 0;
    logic [31:0] wdata = 0;
    logic [31:0] rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, pwm = 0;
    logic awready, wready, bvalid, arready, rvalid, irq, go = 0, plvl = 0;
    logic [1:0] bresp, rresp;
    logic [1:0] psel = 0;
    logic [7:0] pwid = 0, lf = 8'd88, v, w8;
    logic [7:0] mdl[10] = '{default: 8'h00};
    logic [3:0] pins;
    logic [11:0] f;
    int failures = 0;
    int n_checks = 0;
    localparam logic [7:0] WM[10] = '{8'hfb, 8'hff, 0, 0, 8'hff, 8'hff, 0, 0, 0, 8'h03};
    // Filter table: enable, count, clock, expected capture, pulse width
    localparam logic [11:0] FT[8] = '{12'h101, 12'h801, 12'h903, 12'hc03,
                                      12'hd06, 12'hb0c, 12'he0c, 12'hf18};

    mct_motor_capture_timer u_mct_motor_capture_timer (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pwm_periodic_signal(pwm), .hall_input_a(pins[0]), .hall_input_b(pins[1]),
        .hall_input_c(pins[2]), .general_capture_pin(pins[3]), .irq(irq));
    mct_pin_model u_mct_pin_model (.aclk(aclk), .go(go), .sel(psel), .lvl(plvl),
        .width(pwid), .pins(pins));

    initial forever #10 aclk = ~aclk;

    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    function automatic logic [1:0] rsp(input logic [5:0] a);
        return (a >= 6'h28) ? MCT_RESP_SLVERR : MCT_RESP_OKAY;
    endfunction

    task automatic run(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bit ad;
        bit dd;
        ad = 0;
        dd = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            ad = ad | awready;
            dd = dd | wready;
            awvalid <= !ad;
            wvalid <= !dd;
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        bready <= 0;
        `CHK(bresp, rsp(a))
        if (a < 6'h28 && a != MCT_OFF_IRQ_STATUS) mdl[a[5:2]] = d & WM[a[5:2]];
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 0;
        d = rdata[7:0];
        `CHK(rresp, rsp(a))
        `CHK(rdata[31:8], 24'h0)
    endtask

    task automatic chk(input logic [5:0] a);
        rd(a, v);
        `CHK(v, mdl[a[5:2]])
    endtask

    task automatic pin(input logic [1:0] s, input logic l, input logic [7:0] w);
        @(posedge aclk);
        psel <= s;
        plvl <= l;
        pwid <= w;
        go <= 1;
        @(posedge aclk);
        go <= 0;
    endtask

    task automatic report_and_stop;
        if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Limit sized for the divider sweep, the longest part of the run
    initial begin
        run(60000);
        failures++;
        report_and_stop;
    end

    initial begin
        run(3);
        aresetn <= 1;
        run(2);
        for (int i = 0; i < 10; i++) chk(6'(i * 4));
        rd(6'h28, v);
        wr(6'h3c, 8'hff);
        // Timer bit kept low so the read-only counter must stay zero
        repeat (3) begin
            for (int i = 0; i < 6; i++) begin
                lf = lfsr(lf);
                wr(6'(i * 4), lf & 8'hf7);
            end
            for (int i = 0; i < 6; i++) chk(6'(i * 4));
        end
        wr(MCT_OFF_CTRL_B, 8'h00);
        for (int k = 1; k < 8; k++) begin
            wr(MCT_OFF_CTRL_A, {1'b0, 3'(k), 4'h8});
            run(64 << k);
            rd(MCT_OFF_CNT_LO, v);
            `CHK(v >= 63 && v <= 68, 1'b1)
            wr(MCT_OFF_CTRL_A, 8'h00);
        end
        wr(MCT_OFF_CTRL_A, 8'h08);
        repeat (10) begin
            pwm <= 1;
            run(3);
            pwm <= 0;
            run(3);
        end
        run(20);
        rd(MCT_OFF_CNT_LO, v);
        `CHK(v, 8'd10)
        wr(MCT_OFF_CTRL_A, 8'h18);
        run(100);
        wr(MCT_OFF_CTRL_A, 8'h98);
        rd(MCT_OFF_CNT_LO, w8);
        run(30);
        rd(MCT_OFF_CNT_LO, v);
        `CHK(v, w8)
        wr(MCT_OFF_CTRL_A, 8'h18);
        run(30);
        rd(MCT_OFF_CNT_LO, v);
        `CHK(v > w8, 1'b1)
        wr(MCT_OFF_CTRL_A, 8'h10);
        rd(MCT_OFF_CNT_LO, w8);
        run(30);
        rd(MCT_OFF_CNT_LO, v);
        `CHK(v, w8)
        wr(MCT_OFF_CTRL_A, 8'h18);
        rd(MCT_OFF_CNT_LO, v);
        `CHK(v < 8'd8, 1'b1)
        wr(MCT_OFF_CMP_LO, 8'd20);
        wr(MCT_OFF_CMP_HI, 8'h00);
        for (int c = 0; c < 2; c++) begin
            wr(MCT_OFF_CTRL_A, 8'h00);
            wr(MCT_OFF_IRQ_STATUS, 8'h03);
            wr(MCT_OFF_IRQ_MASK, 8'(c * 2));
            wr(MCT_OFF_CTRL_B, 8'(c));
            wr(MCT_OFF_CTRL_A, 8'h18);
            run(120);
            rd(MCT_OFF_CNT_LO, v);
            `CHK(v <= 20, c == 1)
            rd(MCT_OFF_IRQ_STATUS, v);
            `CHK(v[1], 1'b1)
            `CHK(irq, c == 1)
            wr(MCT_OFF_CTRL_A, 8'h00);
            wr(MCT_OFF_IRQ_STATUS, 8'h02);
            rd(MCT_OFF_IRQ_STATUS, v);
            `CHK(v[1], 1'b0)
            `CHK(irq, 1'b0)
        end
        for (int s = 0; s < 4; s++) for (int e = 0; e < 4; e++) for (int k = 0; k < 3; k++) begin
            wr(MCT_OFF_CTRL_B, {2'(e), k != 1, 5'h0});
            wr(MCT_OFF_CTRL_A, {4'h1, k != 2, 1'b0, 2'(s)});
            wr(MCT_OFF_IRQ_STATUS, 8'h01);
            pin(2'(s + 1), 1'b1, 8'd8);
            run(12);
            pin(2'(s), 1'b1, 8'd0);
            run(6);
            rd(MCT_OFF_IRQ_STATUS, v);
            `CHK(v[0], k == 0 && e[0])
            wr(MCT_OFF_IRQ_STATUS, 8'h01);
            pin(2'(s), 1'b0, 8'd0);
            run(6);
            rd(MCT_OFF_IRQ_STATUS, v);
            `CHK(v[0], k == 0 && e[1])
        end
        wr(MCT_OFF_CTRL_A, 8'h00);
        wr(MCT_OFF_CTRL_B, 8'h62);
        wr(MCT_OFF_CTRL_A, 8'h18);
        wr(MCT_OFF_IRQ_STATUS, 8'h01);
        run(300);
        pin(2'd0, 1'b1, 8'd0);
        run(6);
        rd(MCT_OFF_CAP_LO, v);
        rd(MCT_OFF_CAP_HI, w8);
        `CHK({w8, v} >= 150 && {w8, v} <= 160, 1'b1)
        rd(MCT_OFF_IRQ_STATUS, v);
        `CHK(v[0], 1'b1)
        rd(MCT_OFF_CNT_LO, v);
        `CHK(v < 8'd12, 1'b1)
        pin(2'd0, 1'b0, 8'd0);
        for (int i = 0; i < 8; i++) begin
            f = FT[i];
            wr(MCT_OFF_CTRL_A, 8'h00);
            wr(MCT_OFF_CTRL_B, {2'b01, 1'b1, f[10], f[9], f[11], 2'b00});
            wr(MCT_OFF_CTRL_A, 8'h18);
            wr(MCT_OFF_IRQ_STATUS, 8'h01);
            pin(2'd0, 1'b1, f[7:0]);
            run(40);
            rd(MCT_OFF_IRQ_STATUS, v);
            `CHK(v[0], f[8])
        end
        report_and_stop;
    end
endmodule
